/* pkg/jbs_pkg.sv */
/*
 * Constants and types shared by the boundary-scan test port.
 * Assumes a standard four-wire test controller outside the device.
 */
package jbs_pkg;

    localparam int IR_LEN = 2;
    localparam int BSR_LEN = 118;
    localparam logic [1:0] IR_CAPTURE = 2'h1;
    localparam logic [1:0] IR_RESET = 2'h3;
    localparam logic [2:0] CODE_EXTEST_LO = 3'h0;
    localparam logic [2:0] CODE_EXTEST_HI = 3'h1;
    localparam logic [2:0] CODE_BYPASS_LO = 3'h6;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0]
    {
        INS_EXTEST = 2'h0,
        INS_SAMPLE = 2'h1,
        INS_BYPASS = 2'h2
    } jbs_instr_t;

    typedef enum logic [15:0]
    {
        ST_RESET = 16'h0001,
        ST_IDLE = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } jbs_state_t;

endpackage

/* rtl/jbs_sync.sv */
/*
 * Two-flop level synchroniser, any width.
 * Assumes each bit is a level or a slow toggle; words need a handshake.
 */
`timescale 1ns/1ns
module jbs_sync
    import jbs_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    // Destination clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds the second stage only
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            q <= '0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

/* rtl/jbs_tap_port.sv */
/*
 * Boundary-scan test access port: TAP controller, two-bit instruction
 * register, bypass register and a boundary-scan register of BSR_LEN cells.
 * Assumes the test clock is unrelated to clk and that trst_n, tms and tdi
 * come from the test controller, synchronous to tck.
 */
// Overview of operation
// - Test logic runs on tck alone, core undisturbed; pin capture and pad update also use clk
// - TMS sampled on rising tck edges
// - Undriven TMS, TDI, TRST read high
// - TDI captured on rising tck into register
// - TDO shifts out, changes on falling tck
// - TDO high impedance when not shifting
// - TRST resets TAP and instruction register
// - Two-bit IR shifted in Shift-IR, loaded only in Update-IR or Test-Logic-Reset
// - Instruction selects data register and path
// - Only public instructions, no private ones
// - Exactly two data registers: boundary, bypass
// - Bypass is one flip-flop path
// - 118 boundary cells, cell 0 out first
// - Three-state control cells enable on one
`timescale 1ns/1ns
module jbs_tap_port
    import jbs_pkg::*;
#(
    parameter int CELLS = BSR_LEN
)
(
    // System clock domain
    input wire logic clk,
    input wire logic rst_n,
    // Test access port, tck domain
    input wire logic tck,
    input wire logic trst_n,
    input wire logic trstDriven,
    input wire logic tms,
    input wire logic tmsDriven,
    input wire logic tdi,
    input wire logic tdiDriven,
    output logic tdo,
    output logic tdoOe,
    // Pad side: values seen at the device pins
    input wire logic [CELLS-1:0] pinIn,
    // Core side: what the core would drive
    input wire logic [CELLS-1:0] coreOut,
    // Cell values after the test mux, clk domain
    output logic [CELLS-1:0] padOut,
    output logic extestActive
);

    // Maps the two-bit code onto the upper bits of the decode table
    function automatic jbs_instr_t decodeInstr(input logic [IR_LEN-1:0] ir);
        logic [2:0] code;
        code = {ir, 1'b0};
        if (code == CODE_EXTEST_LO || code == CODE_EXTEST_HI)
            decodeInstr = INS_EXTEST;
        else if (code >= CODE_BYPASS_LO)
            decodeInstr = INS_BYPASS;
        else
            decodeInstr = INS_SAMPLE;
    endfunction

    jbs_state_t state_q;
    jbs_state_t state_d;
    logic [IR_LEN-1:0] irShift_q;
    logic [IR_LEN-1:0] irCur_q;
    logic bypass_q;
    logic [CELLS-1:0] bsrShift_q;
    logic [CELLS-1:0] bsrUpd_q;
    logic updToggle_q;
    logic tdo_q;
    logic tdoOe_q;
    logic [CELLS-1:0] pinSnap_q;
    logic [CELLS-1:0] pinTck;
    logic [CELLS-1:0] bsrDrive_q;
    logic updSeen_q;
    logic updSync;
    logic extestSync;
    logic tckReset_n;

    wire tmsEff = tms | ~tmsDriven;
    wire tdiEff = tdi | ~tdiDriven;
    wire trstEff_n = trst_n | ~trstDriven;
    wire jbs_instr_t instr = decodeInstr(irCur_q);
    wire selBypass = (instr == INS_BYPASS);
    wire extestTck = (instr == INS_EXTEST);
    wire inShiftIr = (state_q == ST_SHIFT_IR);
    wire inShiftDr = (state_q == ST_SHIFT_DR);
    wire drOutBit = selBypass ? bypass_q : bsrShift_q[0];
    wire outBit = inShiftIr ? irShift_q[0] : drOutBit;

    assign tckReset_n = trstEff_n;

    // TAP next state
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_RESET: state_d = tmsEff ? ST_RESET : ST_IDLE;
            ST_IDLE: state_d = tmsEff ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_d = tmsEff ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_d = tmsEff ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_d = tmsEff ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_d = tmsEff ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: state_d = tmsEff ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_d = tmsEff ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: state_d = tmsEff ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_d = tmsEff ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_d = tmsEff ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_d = tmsEff ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_d = tmsEff ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: state_d = tmsEff ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_d = tmsEff ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: state_d = tmsEff ? ST_SEL_DR : ST_IDLE;
            default: state_d = ST_RESET;
        endcase
    end

    // TMS steers the controller on the rising edge
    always_ff @(posedge tck or negedge tckReset_n)
    begin
        if (!tckReset_n)
            state_q <= ST_RESET;
        else
            state_q <= state_d;
    end

    // Instruction register: shift stage and current instruction
    always_ff @(posedge tck or negedge tckReset_n)
    begin
        if (!tckReset_n)
        begin
            irShift_q <= IR_CAPTURE;
            irCur_q <= IR_RESET;
        end
        else
        begin
            if (state_q == ST_CAP_IR)
                irShift_q <= IR_CAPTURE;
            else if (inShiftIr)
                irShift_q <= {tdiEff, irShift_q[IR_LEN-1:1]};
            if (state_q == ST_RESET)
                irCur_q <= IR_RESET;
            else if (state_q == ST_UPD_IR)
                irCur_q <= irShift_q;
        end
    end

    // Bypass: a single stage, captures zero
    always_ff @(posedge tck or negedge tckReset_n)
    begin
        if (!tckReset_n)
            bypass_q <= 1'b0;
        else if (selBypass && state_q == ST_CAP_DR)
            bypass_q <= 1'b0;
        else if (selBypass && inShiftDr)
            bypass_q <= tdiEff;
    end

    // Boundary shift stage; cell 0 sits next to TDO
    always_ff @(posedge tck or negedge tckReset_n)
    begin
        if (!tckReset_n)
            bsrShift_q <= '0;
        else if (!selBypass && state_q == ST_CAP_DR)
            bsrShift_q <= pinTck;
        else if (!selBypass && inShiftDr)
            bsrShift_q <= {tdiEff, bsrShift_q[CELLS-1:1]};
    end

    // Update stage holds still while shifting goes on
    always_ff @(posedge tck or negedge tckReset_n)
    begin
        if (!tckReset_n)
        begin
            bsrUpd_q <= '0;
            updToggle_q <= 1'b0;
        end
        else if (!selBypass && state_q == ST_UPD_DR)
        begin
            bsrUpd_q <= bsrShift_q;
            updToggle_q <= ~updToggle_q;
        end
    end

    // TDO changes on the falling edge, mid bit for the controller
    always_ff @(negedge tck or negedge tckReset_n)
    begin
        if (!tckReset_n)
        begin
            tdo_q <= 1'b0;
            tdoOe_q <= 1'b0;
        end
        else
        begin
            tdo_q <= outBit;
            tdoOe_q <= inShiftIr | inShiftDr;
        end
    end

    assign tdo = tdo_q;
    assign tdoOe = tdoOe_q;

    // Pin values are registered in clk, then synchronised into tck
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pinSnap_q <= '0;
        else
            pinSnap_q <= pinIn;
    end

    // Capture may see a pin mid change; pins are quasi-static under test
    jbs_sync #(
        .WIDTH(CELLS)
    ) u_pinSync (
        .clk(tck),
        .rst_n(tckReset_n),
        .d(pinSnap_q),
        .q(pinTck)
    );

    jbs_sync #(
        .WIDTH(1)
    ) u_updSync (
        .clk(clk),
        .rst_n(rst_n),
        .d(updToggle_q),
        .q(updSync)
    );

    jbs_sync #(
        .WIDTH(1)
    ) u_extSync (
        .clk(clk),
        .rst_n(rst_n),
        .d(extestTck),
        .q(extestSync)
    );

    // Toggle handshake: update word is stable for many clk cycles
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            updSeen_q <= 1'b0;
            bsrDrive_q <= '0;
            extestActive <= 1'b0;
        end
        else
        begin
            updSeen_q <= updSync;
            if (updSync != updSeen_q)
                bsrDrive_q <= bsrUpd_q;
            extestActive <= extestSync;
        end
    end

    // Control cells pass unchanged: one enables the driver
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            padOut <= '0;
        else
            padOut <= extestActive ? bsrDrive_q : coreOut;
    end

endmodule

/* testbench/jbs_tap_port_chk.sv */
/* Checker for jbs_tap_port: TAP walks, TDO timing, pad mux.
   Bound to every jbs_tap_port; sees its ports only. */
`timescale 1ns/1ns
module jbs_tap_port_chk
    import jbs_pkg::*;
#(
    parameter int CELLS = BSR_LEN
)
(
    // Clocks and resets
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic trst_n,
    input wire logic trstDriven,
    // Serial pins
    input wire logic tms,
    input wire logic tmsDriven,
    input wire logic tdo,
    input wire logic tdoOe,
    // Pads
    input wire logic [CELLS-1:0] coreOut,
    input wire logic [CELLS-1:0] padOut,
    input wire logic extestActive
);
    // Undriven pins read high
    wire logic trstEff = trstDriven ? trst_n : 1'b1;
    wire logic tmsHi = tmsDriven ? tms : 1'b1;

    a_tdo_hold: assert property (@(posedge clk)
        disable iff (!trstEff) tck && $past(tck) |-> $stable(tdo))
        else $error("tdo moved");
    a_tms_reset: assert property (@(posedge tck)
        disable iff (!trstEff) tmsHi[*5] |=> !tdoOe)
        else $error("no reset by tms");
    a_ir_capture: assert property (@(posedge tck)
        disable iff (!trstEff) tmsHi[*5] ##1 !tmsHi ##1 tmsHi[*2]
        ##1 (!tmsHi)[*2] |=> tdoOe && tdo)
        else $error("bad ir capture");
    a_byp_capture: assert property (@(posedge tck)
        disable iff (!trstEff) tmsHi[*5] ##1 !tmsHi ##1 tmsHi
        ##1 (!tmsHi)[*2] |=> tdoOe && !tdo)
        else $error("bad bypass capture");
    a_oe_drops: assert property (@(posedge tck)
        disable iff (!trstEff) tdoOe && tmsHi |=> !tdoOe)
        else $error("tdo driven off shift");
    a_oe_stays: assert property (@(posedge tck)
        disable iff (!trstEff) tdoOe && !tmsHi |=> tdoOe)
        else $error("tdo off in shift");
    a_oe_trst: assert property (@(posedge clk)
        disable iff (!rst_n) (!trstEff)[*2] |-> !tdoOe && !tdo)
        else $error("trst ignored");
    a_pad_core: assert property (@(posedge clk)
        disable iff (!rst_n) (!extestActive)[*4]
        |=> extestActive || padOut == $past(coreOut))
        else $error("pads not from core");

    c_ir: cover property (@(posedge tck) tdoOe && tdo);
    c_extest: cover property (@(posedge clk) $rose(extestActive));
    c_pullup: cover property (@(posedge tck) (!tmsDriven)[*5]);
endmodule

bind jbs_tap_port jbs_tap_port_chk #(.CELLS(CELLS)) chk (.*);

/* testbench/jbs_ctrl_model.sv */
/* Test controller model: owns tck, tms, tdi, trst and pin drive state.
   tck idles low and runs only inside a scan, 160 ns period.
   A released tdo reads as its inverse, so a late enable shows up. */
`timescale 1ns/1ns
module jbs_ctrl_model
(
    // Test pins
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    output logic trstDriven,
    output logic tmsDriven,
    output logic tdiDriven,
    input wire logic tdo,
    input wire logic tdoOe
);
    initial
        {tck, tms, tdi, trst_n, trstDriven, tmsDriven, tdiDriven} = 7'h37;

    task automatic pins(input logic [3:0] p);
        {trst_n, trstDriven, tmsDriven, tdiDriven} = p;
    endtask

    // Undriven pins toggle so a stale level never passes for a pull-up
    task automatic scan(input logic [127:0] t, d, input int n,
        output logic [127:0] o);
        o = 128'h0;
        for (int i = 0; i < n; i++)
        begin
            tms <= tmsDriven ? t[i] : ~tms;
            tdi <= tdiDriven ? d[i] : ~tdi;
            #80 tck = 1'b1;
            o[i] = tdoOe ? tdo : ~tdo;
            #80 tck = 1'b0;
        end
    endtask
endmodule

/* testbench/jbs_tap_port_tb.sv */
/* Bench for jbs_tap_port: controller model, random pads, checker bound.
   Expected scan-out and pad values are worked out here. */
`timescale 1ns/1ns
module jbs_tap_port_tb
    import jbs_pkg::*;
;
    logic clk, rst_n, tck, trst_n, trstDriven, tms, tmsDriven, tdi;
    logic tdiDriven, tdo, tdoOe, extestActive;
    logic [BSR_LEN-1:0] pinIn, coreOut, padOut, data, prevCore;
    logic [127:0] o, e, m;
    int fails, samples_checked, seed, k, j;

    jbs_tap_port uut (.*);
    jbs_ctrl_model ctl (.*);

    task automatic check(input logic [127:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        if (fails == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    function automatic logic [BSR_LEN-1:0] rnd();
        logic [127:0] r;
        r = {$random(seed), $random(seed), $random(seed), $random(seed)};
        return r[BSR_LEN-1:0];
    endfunction

    // Pad side follows the instruction a few clk later
    task automatic settle(input int ins);
        j = 0;
        while (j < 20 && (extestActive !== (ins == 0)
            || ins == 0 && padOut !== data))
        begin
            j++;
            @(negedge clk);
        end
        check(128'(j < 20), 128'h1);
        if (j == 20)
            print_verdict();
        // Outside EXTEST the pads follow the core one clk later
        if (ins != 0)
        begin
            @(posedge clk) prevCore = coreOut;
            @(negedge clk) check(128'(padOut), 128'(prevCore));
        end
    endtask

    task automatic do_dr(input int ins);
        int n;
        n = ins == 3 ? 8 : BSR_LEN;
        @(posedge clk) pinIn <= rnd();
        data = rnd();
        // A floating tdi is pulled high
        if (!tdiDriven)
            data = '1;
        ctl.scan((128'h3 << (n + 2)) | 128'h1, 128'(data) << 3, n + 5, o);
        m = ((128'h1 << n) - 1) << 3;
        e = (ins == 3 ? {data, 1'b0} : 128'(pinIn)) << 3;
        check(o & m, e & m);
        settle(ins);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
        coreOut <= rnd();

    initial
    begin
        seed = 32'hc60bfdd4;
        {rst_n, pinIn, coreOut} = 237'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        ctl.pins(4'hf);
        ctl.scan(128'h1f, 128'h0, 6, o);
        for (k = 3; k >= 0; k--)
        begin
            ctl.scan(128'h63, 128'(k) << 4, 8, o);
            check(o & 128'h30, 128'h10);
            do_dr(k);
        end
        ctl.pins(4'h7);
        settle(3);
        ctl.pins(4'h0);
        ctl.scan(128'h1f, 128'h0, 6, o);
        // trst held low but floating, tdi floating: both read high
        ctl.pins(4'h2);
        ctl.scan(128'h0, 128'h0, 1, o);
        do_dr(3);
        print_verdict();
    end
endmodule
